// [design/csb_pkg.sv]
// Purpose: constants and carrier types of the core register bank
// Assumes: register space 80h..FFh, one byte per address
// Notes: bits outside each storage mask are not held and read as zero
package csb_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PTR_W = 16;
  localparam int NUM_PTR = 2;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PORT_ZERO = 8'h80;
  localparam logic [7:0] OFS_STACK_TOP = 8'h81;
  localparam logic [7:0] OFS_PTR_LOW = 8'h82;
  localparam logic [7:0] OFS_PTR_HIGH = 8'h83;
  localparam logic [7:0] OFS_POWER = 8'h87;
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h88;
  localparam logic [7:0] OFS_TIMER_MODE = 8'h89;
  localparam logic [7:0] OFS_TIMER0_LOW = 8'h8A;
  localparam logic [7:0] OFS_TIMER1_LOW = 8'h8B;
  localparam logic [7:0] OFS_TIMER0_HIGH = 8'h8C;
  localparam logic [7:0] OFS_TIMER1_HIGH = 8'h8D;
  localparam logic [7:0] OFS_CLOCK_CTRL = 8'h8F;
  localparam logic [7:0] OFS_PORT_ONE = 8'h90;
  localparam logic [7:0] OFS_SERIAL_CTRL = 8'h98;
  localparam logic [7:0] OFS_SERIAL_BUF = 8'h99;
  localparam logic [7:0] OFS_PORT_TWO = 8'hA0;
  localparam logic [7:0] OFS_AUX_ONE = 8'hA2;
  localparam logic [7:0] OFS_INT_ENABLE = 8'hA8;
  localparam logic [7:0] OFS_SLAVE_ADDR = 8'hA9;
  localparam logic [7:0] OFS_PORT_THREE = 8'hB0;
  localparam logic [7:0] OFS_INT_PRIO_HIGH = 8'hB7;
  localparam logic [7:0] OFS_INT_PRIO = 8'hB8;
  localparam logic [7:0] OFS_SLAVE_MASK = 8'hB9;
  localparam logic [7:0] OFS_PROG_STATUS = 8'hD0;
  localparam logic [7:0] OFS_MAIN_WORK = 8'hE0;
  localparam logic [7:0] OFS_SECOND_OPND = 8'hF0;

  // ---------------------------------------------------------------
  // generic storage table (pointer bytes are handled apart)
  // ---------------------------------------------------------------
  localparam int NUM_GEN = 24;
  localparam int IX_CLOCK_CTRL = 10;
  localparam int IX_AUX_ONE = 15;

  localparam logic [7:0] GEN_OFS [NUM_GEN] = '{
    OFS_PORT_ZERO, OFS_STACK_TOP, OFS_POWER, OFS_TIMER_CTRL,
    OFS_TIMER_MODE, OFS_TIMER0_LOW, OFS_TIMER1_LOW, OFS_TIMER0_HIGH,
    OFS_TIMER1_HIGH, OFS_PORT_ONE, OFS_CLOCK_CTRL, OFS_SERIAL_CTRL,
    OFS_SERIAL_BUF, OFS_PORT_TWO, OFS_INT_ENABLE, OFS_AUX_ONE,
    OFS_SLAVE_ADDR, OFS_PORT_THREE, OFS_INT_PRIO_HIGH, OFS_INT_PRIO,
    OFS_SLAVE_MASK, OFS_PROG_STATUS, OFS_MAIN_WORK, OFS_SECOND_OPND
  };

  localparam logic [7:0] GEN_RST [NUM_GEN] = '{
    8'hFF, 8'h07, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  localparam logic [7:0] GEN_MASK [NUM_GEN] = '{
    8'hFF, 8'hFF, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'h9F, 8'h01,
    8'hFF, 8'hFF, 8'h1F, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF
  };

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int DOUBLE_SPEED_BIT = 0;
  localparam int POINTER_SELECT_BIT = 0;
  localparam logic [7:0] PTR_BYTE_RST = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // ---------------------------------------------------------------
  // timing counts, oscillator cycles
  // ---------------------------------------------------------------
  localparam int CYC_STANDARD = 12;
  localparam int CYC_DOUBLE = 6;
  localparam int PER_STANDARD = 2;
  localparam int PER_DOUBLE = 1;
  localparam logic [3:0] INSTR_LAST_STD = 4'(CYC_STANDARD - 1);
  localparam logic [3:0] INSTR_LAST_DBL = 4'(CYC_DOUBLE - 1);
  localparam logic [1:0] PER_LAST_STD = 2'(PER_STANDARD - 1);
  localparam logic [1:0] PER_LAST_DBL = 2'(PER_DOUBLE - 1);

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } csb_bus_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] bitAddr;
    logic bitVal;
    logic wr;
  } csb_bit_req_t;

  typedef struct packed {
    logic [PTR_W-1:0] value;
    logic load;
    logic incr;
  } csb_ptr_cmd_t;

  typedef struct packed {
    logic instrTick;
    logic periphTick;
    logic doubleSpeed;
  } csb_time_t;

endpackage : csb_pkg

// [design/csb_sfr_bank.sv]
// Purpose: core register bank with clock-mode divider and dual pointer
// Assumes: mclk is the oscillator clock, core logic shares it
// Notes: registers sit at their own addresses on the plain port
//
// Overview of operation
// R1: Clock-mode bit set gives 6 cycles an instruction, clear gives 12.
// R2: Reset leaves the part in standard speed with the clock-mode bit clear.
// R3: In double speed the peripheral time base ticks twice as often.
// R4: Two independent 16-bit data pointers are held.
// R5: The selected pointer gives every data address and takes every op.
// R6: Pointer select is bit 0 of the auxiliary register, set by software.
// R7: Select 0 makes the first pointer active, select 1 the second.
// R8: The auxiliary register resets with select 0, ignores bit writes.
// R9: Auxiliary bits 7 to 1 are reserved and must not be written as ones.
// R10: Clock-mode bit is bit 0 of clock control, other bits reserved.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps

module csb_sfr_bank (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register port
  input wire csb_pkg::csb_bus_req_t busReq,
  output logic [csb_pkg::DATA_W-1:0] busRdata,
  // single-bit write port
  input wire csb_pkg::csb_bit_req_t bitReq,
  // pointer operations from the core
  input wire csb_pkg::csb_ptr_cmd_t ptrCmd,
  // external data address and time base
  output logic [csb_pkg::PTR_W-1:0] dataPointer,
  output csb_pkg::csb_time_t timeBase
);

  // ---------------------------------------------------------------
  // generic storage
  // ---------------------------------------------------------------
  logic [7:0] regVal_r [csb_pkg::NUM_GEN];
  wire [7:0] bitReg = {bitReq.bitAddr[7:3], 3'h0};
  wire [7:0] bitOne = 8'h01 << bitReq.bitAddr[2:0];
  wire bitLegal = bitReq.wr && bitReq.bitAddr[7];

  genvar g;
  generate
    for (g = 0; g < csb_pkg::NUM_GEN; g++) begin : gReg
      wire byteHit = busReq.wr && (busReq.addr == csb_pkg::GEN_OFS[g]);
      // only column-0 registers answer bit writes; aux one never does
      wire bitHit = bitLegal && (csb_pkg::GEN_OFS[g][2:0] == 3'h0) &&
        (bitReg == csb_pkg::GEN_OFS[g]); // [R8]
      wire [7:0] bitMerged = bitReq.bitVal ? (regVal_r[g] | bitOne) :
        (regVal_r[g] & ~bitOne);
      // reserved bits are masked out and never stored [R9] [R10]
      wire [7:0] byteNxt = busReq.wdata & csb_pkg::GEN_MASK[g];
      wire [7:0] bitNxt = bitMerged & csb_pkg::GEN_MASK[g];

      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          regVal_r[g] <= csb_pkg::GEN_RST[g]; // [R2] [R8]
        end else if (byteHit) begin
          regVal_r[g] <= byteNxt; // [R1] [R6]
        end else if (bitHit) begin
          regVal_r[g] <= bitNxt;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // dual data pointer
  // ---------------------------------------------------------------
  logic [csb_pkg::PTR_W-1:0] ptr_r [csb_pkg::NUM_PTR]; // [R4]
  wire ptrSel =
    regVal_r[csb_pkg::IX_AUX_ONE][csb_pkg::POINTER_SELECT_BIT]; // [R6]
  wire lowWr = busReq.wr && (busReq.addr == csb_pkg::OFS_PTR_LOW);
  wire highWr = busReq.wr && (busReq.addr == csb_pkg::OFS_PTR_HIGH);

  genvar p;
  generate
    for (p = 0; p < csb_pkg::NUM_PTR; p++) begin : gPtr
      wire isActive = (ptrSel == 1'(p)); // [R7]
      wire [csb_pkg::PTR_W-1:0] ptrInc = ptr_r[p] + 16'h0001;
      wire [csb_pkg::PTR_W-1:0] ptrNxt =
        ptrCmd.load ? ptrCmd.value :
        ptrCmd.incr ? ptrInc :
        lowWr ? {ptr_r[p][15:8], busReq.wdata} :
        highWr ? {busReq.wdata, ptr_r[p][7:0]} : ptr_r[p];
      wire ptrUpd = isActive &&
        (ptrCmd.load || ptrCmd.incr || lowWr || highWr); // [R5]

      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          ptr_r[p] <= {csb_pkg::PTR_BYTE_RST, csb_pkg::PTR_BYTE_RST};
        end else if (ptrUpd) begin
          ptr_r[p] <= ptrNxt;
        end
      end
    end
  endgenerate

  wire [csb_pkg::PTR_W-1:0] activePtr = ptrSel ? ptr_r[1] : ptr_r[0];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dataPointer <= {csb_pkg::PTR_BYTE_RST, csb_pkg::PTR_BYTE_RST};
    end else begin
      dataPointer <= activePtr; // [R5]
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] rdMux;
  always_comb begin
    rdMux = csb_pkg::READ_IDLE;
    for (int i = 0; i < csb_pkg::NUM_GEN; i++) begin
      if (busReq.addr == csb_pkg::GEN_OFS[i]) begin
        rdMux = regVal_r[i];
      end
    end
    if (busReq.addr == csb_pkg::OFS_PTR_LOW) begin
      rdMux = activePtr[7:0]; // [R5]
    end
    if (busReq.addr == csb_pkg::OFS_PTR_HIGH) begin
      rdMux = activePtr[15:8]; // [R5]
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busRdata <= csb_pkg::READ_IDLE;
    end else begin
      busRdata <= busReq.rd ? rdMux : csb_pkg::READ_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // clock-mode divider
  // ---------------------------------------------------------------
  wire dblSpeed =
    regVal_r[csb_pkg::IX_CLOCK_CTRL][csb_pkg::DOUBLE_SPEED_BIT]; // [R10]
  wire [3:0] instrLast = dblSpeed ? csb_pkg::INSTR_LAST_DBL :
    csb_pkg::INSTR_LAST_STD; // [R1]
  wire [1:0] perLast = dblSpeed ? csb_pkg::PER_LAST_DBL :
    csb_pkg::PER_LAST_STD; // [R3]
  logic [3:0] instrCnt_r;
  logic [1:0] perCnt_r;
  // a switch to double speed with the count past 5 wraps at once, no long cycle
  wire instrEnd = (instrCnt_r >= instrLast); // [R1]
  wire perEnd = (perCnt_r >= perLast); // [R3]
  wire [3:0] instrCnt_nxt = instrEnd ? 4'h0 : instrCnt_r + 4'h1;
  wire [1:0] perCnt_nxt = perEnd ? 2'h0 : perCnt_r + 2'h1;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      instrCnt_r <= 4'h0;
      perCnt_r <= 2'h0;
      timeBase <= '0; // [R2]
    end else begin
      instrCnt_r <= instrCnt_nxt;
      perCnt_r <= perCnt_nxt;
      timeBase.instrTick <= instrEnd; // [R1]
      timeBase.periphTick <= perEnd; // [R3]
      timeBase.doubleSpeed <= dblSpeed;
    end
  end

endmodule : csb_sfr_bank

// [testbench/csb_sfr_bank_assertions.sv]
// Purpose: port assertions for the core register bank
// Assumes: one clock mclk, asynchronous reset arst_n
// Notes: attached to csb_sfr_bank by bind
`timescale 1ns/100ps

module csb_sfr_bank_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // watched ports
  input wire csb_pkg::csb_bus_req_t busReq,
  input wire logic [csb_pkg::DATA_W-1:0] busRdata,
  input wire csb_pkg::csb_ptr_cmd_t ptrCmd,
  input wire logic [csb_pkg::PTR_W-1:0] dataPointer,
  input wire csb_pkg::csb_time_t timeBase
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------
  // sequences and properties
  // ---------------------------------------------------------------
  sequence ckWr;
    busReq.wr && busReq.addr == csb_pkg::OFS_CLOCK_CTRL;
  endsequence
  sequence auxRd;
    busReq.rd && busReq.addr == csb_pkg::OFS_AUX_ONE;
  endsequence

  a_read_idle: assert property (!$past(busReq.rd) |-> busRdata == 8'h00)
    else $error("read data not idle");
  a_tick_gap: assert property (
    timeBase.instrTick |=> !timeBase.instrTick [*5])
    else $error("instruction ticks too close");
  a_std_period: assert property (
    timeBase.instrTick && !timeBase.doubleSpeed |->
    ##[1:12] timeBase.instrTick)
    else $error("standard instruction too long");
  a_dbl_period: assert property (
    timeBase.doubleSpeed [*8] |->
    timeBase.instrTick == $past(timeBase.instrTick, 6))
    else $error("double speed period not six");
  a_periph_dbl: assert property (
    timeBase.doubleSpeed [*3] |-> timeBase.periphTick)
    else $error("peripheral tick missing");
  a_periph_std: assert property (
    !timeBase.doubleSpeed [*4] |->
    timeBase.periphTick != $past(timeBase.periphTick))
    else $error("peripheral tick not halved");
  a_ptr_load: assert property (
    ptrCmd.load |-> ##2 dataPointer == $past(ptrCmd.value, 2))
    else $error("pointer load lost");
  a_ptr_incr: assert property (
    ptrCmd.incr && !ptrCmd.load && !busReq.wr |->
    ##2 dataPointer == 16'($past(dataPointer) + 1))
    else $error("pointer increment wrong");
  a_speed_copy: assert property (
    ckWr |-> ##2 timeBase.doubleSpeed == $past(busReq.wdata[0], 2))
    else $error("double speed bit wrong");
  a_aux_reserved: assert property (
    auxRd |=> busRdata[7:1] == 7'h00)
    else $error("reserved bits not zero");
endmodule : csb_sfr_bank_chk

bind csb_sfr_bank csb_sfr_bank_chk u_chk (.mclk(mclk), .arst_n(arst_n),
  .busReq(busReq), .busRdata(busRdata), .ptrCmd(ptrCmd),
  .dataPointer(dataPointer), .timeBase(timeBase));

// [testbench/csb_sfr_bank_bench.sv]
// Purpose: self-checking bench for the core register bank
// Assumes: inputs driven by non-blocking assignment at rising mclk
// Notes: read data sampled on the falling edge after the strobe
`timescale 1ns/100ps

module csb_sfr_bank_bench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  csb_pkg::csb_bus_req_t busReq = '0;
  csb_pkg::csb_bit_req_t bitReq = '0;
  csb_pkg::csb_ptr_cmd_t ptrCmd = '0;
  logic [7:0] busRdata;
  logic [15:0] dataPointer;
  csb_pkg::csb_time_t timeBase;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  int gapv;
  logic [7:0] rdv;
  // address and expected reset value, C0 is unmapped
  localparam logic [15:0] ROWS [10] = '{16'h80FF, 16'h8107, 16'h8710,
    16'h8800, 16'h8F00, 16'h90FF, 16'hA200, 16'hB0FF, 16'hE000, 16'hC000};

  always #5 mclk = ~mclk;

  csb_sfr_bank dut (.mclk(mclk), .arst_n(arst_n), .busReq(busReq),
    .busRdata(busRdata), .bitReq(bitReq), .ptrCmd(ptrCmd),
    .dataPointer(dataPointer), .timeBase(timeBase));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk) busReq <= {a, d, 2'b10};
    @(posedge mclk) busReq <= '0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge mclk) busReq <= {a, 8'h00, 2'b01};
    @(posedge mclk) busReq <= '0;
    @(negedge mclk) rdv = busRdata;
  endtask : rd
  // spacing of two instruction ticks, called on a falling edge
  task automatic gap();
    int n;
    n = 0;
    gapv = 0;
    while (timeBase.instrTick !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    do begin
      @(negedge mclk);
      gapv++;
    end while (timeBase.instrTick !== 1'b1 && gapv < 20);
  endtask : gap
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (ROWS[i]) begin
      rd(ROWS[i][15:8]);
      chk("reset value", {8'h00, ROWS[i][7:0]}, {8'h00, rdv});
    end
    $display("reset table done");
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    wr(8'hA2, 8'h01);
    wr(8'h82, 8'hCD);
    wr(8'h83, 8'hAB);
    repeat (2) @(negedge mclk);
    chk("second pointer", 16'hABCD, dataPointer);
    rd(8'hA2);
    chk("aux read", 16'h0001, {8'h00, rdv});
    wr(8'hA2, 8'h00);
    repeat (2) @(negedge mclk);
    chk("first pointer", 16'h1234, dataPointer);
    rd(8'h83);
    chk("high byte", 16'h0012, {8'h00, rdv});
    @(posedge mclk) ptrCmd <= {16'hFFFF, 2'b10};
    @(posedge mclk) ptrCmd <= {16'h0000, 2'b01};
    @(posedge mclk) ptrCmd <= '0;
    repeat (2) @(negedge mclk);
    chk("wrapped pointer", 16'h0000, dataPointer);
    wr(8'hA2, 8'h01);
    repeat (2) @(negedge mclk);
    chk("kept pointer", 16'hABCD, dataPointer);
    @(posedge mclk) bitReq <= {8'h8C, 2'b11};
    @(posedge mclk) bitReq <= '0;
    rd(8'h88);
    chk("bit write", 16'h0010, {8'h00, rdv});
    @(posedge mclk) bitReq <= {8'hA2, 2'b01};
    @(posedge mclk) bitReq <= '0;
    rd(8'hA2);
    chk("aux bit write", 16'h0001, {8'h00, rdv});
    rd(8'hA0);
    chk("column bit write", 16'h00FB, {8'h00, rdv});
    $display("pointer tests done");
    gap();
    gap();
    chk("standard gap", 16'h000C, 16'(gapv));
    wr(8'h8F, 8'h01);
    @(negedge mclk);
    gap();
    gap();
    chk("double gap", 16'h0006, 16'(gapv));
    chk("speed flag", 16'h0001, {15'h0000, timeBase.doubleSpeed});
    chk("fast periph", 16'h0001, {15'h0000, timeBase.periphTick});
    wr(8'h8F, 8'h00);
    @(negedge mclk);
    gap();
    gap();
    chk("back to standard", 16'h000C, 16'(gapv));
    rdv[0] = timeBase.periphTick;
    @(negedge mclk);
    chk("slow periph", {15'h0000, ~rdv[0]}, {15'h0000, timeBase.periphTick});
    $display("speed tests done");
    @(posedge mclk) arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    rd(8'hA2);
    chk("aux after reset", 16'h0000, {8'h00, rdv});
    rd(8'h8F);
    chk("speed after reset", 16'h0000, {8'h00, rdv});
    $display("second reset done");
    give_verdict();
  end
endmodule : csb_sfr_bank_bench
